// File: hw/alu_pkg.sv
package alu_pkg;

    // Data width and flag register location
    localparam int          DATA_W       = 8;
    localparam logic [7:0]  FLAG_REG_ADDR = 8'h0a;

    // Flag bit positions
    localparam int CARRY_BIT    = 0;
    localparam int HALF_BIT     = 1;
    localparam int ZERO_BIT     = 2;
    localparam int OVF_BIT      = 3;
    localparam int PDOWN_BIT    = 4;
    localparam int TIMEOUT_BIT  = 5;

    // Value after reset, write mask and read mask
    localparam logic [7:0] FLAG_RESET     = 8'h00;
    localparam logic [7:0] FLAG_SW_MASK   = 8'h0f;
    localparam logic [7:0] FLAG_READ_MASK = 8'h3f;

    // Decimal adjust constants
    localparam logic [3:0] BCD_LIMIT = 4'h9;
    localparam logic [7:0] BCD_LOW6  = 8'h06;
    localparam logic [7:0] BCD_HIGH6 = 8'h60;

    // Operation codes
    typedef enum logic [4:0] {
        OP_NONE             = 5'h00,
        OP_ADD              = 5'h01,
        OP_ADC              = 5'h02,
        OP_SUB              = 5'h03,
        SUBTRACT_WITH_BORROW_OP = 5'h04,
        DECIMAL_ADJUST_OP   = 5'h05,
        OP_AND              = 5'h06,
        OP_OR               = 5'h07,
        OP_XOR              = 5'h08,
        COMPLEMENT_OP       = 5'h09,
        ROTATE_LEFT_OP      = 5'h0a,
        ROTATE_RIGHT_OP     = 5'h0b,
        ROTATE_LEFT_THROUGH_CARRY_OP  = 5'h0c,
        ROTATE_RIGHT_THROUGH_CARRY_OP = 5'h0d,
        OP_INC              = 5'h0e,
        DECREMENT_OP        = 5'h0f,
        SKIP_IF_ZERO_OP     = 5'h10,
        SKIP_IF_NONZERO_OP  = 5'h11,
        INCREMENT_SKIP_ZERO_OP = 5'h12,
        DECREMENT_SKIP_ZERO_OP = 5'h13,
        OP_PASS             = 5'h14
    } alu_op_e;

endpackage

// File: hw/alu_with_flag_register.sv
// Implementation choice: the plain strobed port.
`timescale 1ns/10ps
module alu_with_flag_register #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic                clk,
    input  wire logic                rst,
    // Operation request
    input  wire logic                op_valid,
    input  wire logic [4:0]          op_code,
    input  wire logic [WIDTH-1:0]    operand_a,
    input  wire logic [WIDTH-1:0]    operand_b,
    // Operation answer
    output logic      [WIDTH-1:0]    result,
    output logic                     result_valid,
    output logic                     skip_next,
    // Register port
    input  wire logic [7:0]          reg_addr,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                reg_write,
    input  wire logic                reg_read,
    output logic      [7:0]          reg_rdata,
    // System events
    input  wire logic                watchdog_clear_instruction,
    input  wire logic                halt_instruction,
    input  wire logic                watchdog_timeout,
    // Flag view
    output logic      [7:0]          flags
);

    logic [7:0] flag_q;
    logic [1:0] event_q;  // Timeout, power-down kept apart from arith flags

    // Current flag bits as seen by the ALU
    wire logic c_in = flag_q[alu_pkg::CARRY_BIT];
    wire logic h_in = flag_q[alu_pkg::HALF_BIT];

    alu_pkg::alu_op_e op;
    assign op = alu_pkg::alu_op_e'(op_code);

    // Adder: subtract is a + ~b + 1, borrow-free when carry is set
    // adder operand selection
    wire logic is_sub   = (op == alu_pkg::OP_SUB) || (op == alu_pkg::SUBTRACT_WITH_BORROW_OP);
    wire logic is_arith = is_sub || (op == alu_pkg::OP_ADD) || (op == alu_pkg::OP_ADC);
    wire logic [7:0] add_b = is_sub ? ~operand_b : operand_b;
    wire logic add_cin = (op == alu_pkg::OP_SUB) ? 1'b1 :
                         ((op == alu_pkg::OP_ADC) || (op == alu_pkg::SUBTRACT_WITH_BORROW_OP))
                         ? c_in : 1'b0;
    wire logic [4:0] low_sum  = {1'b0, operand_a[3:0]} + {1'b0, add_b[3:0]} + {4'h0, add_cin};
    wire logic [3:0] mid_sum  = {1'b0, operand_a[6:4]} + {1'b0, add_b[6:4]} + {3'h0, low_sum[4]};
    wire logic [1:0] top_sum  = {1'b0, operand_a[7]} + {1'b0, add_b[7]} + {1'b0, mid_sum[3]};
    wire logic [7:0] add_res  = {top_sum[0], mid_sum[2:0], low_sum[3:0]};
    // carry into versus out of MSB
    wire logic add_ovf = mid_sum[3] ^ top_sum[1];

    wire logic       da_low  = (operand_a[3:0] > alu_pkg::BCD_LIMIT) || h_in;
    wire logic [8:0] da_s1   = {1'b0, operand_a} + (da_low ? {1'b0, alu_pkg::BCD_LOW6} : 9'h000);
    wire logic       da_high = (da_s1[7:4] > alu_pkg::BCD_LIMIT) || c_in || da_s1[8];
    wire logic [8:0] da_s2   = {1'b0, da_s1[7:0]}
                               + (da_high ? {1'b0, alu_pkg::BCD_HIGH6} : 9'h000);
    wire logic       da_c    = c_in || da_s1[8] || da_s2[8] || da_high;

    wire logic [7:0] inc_res = operand_a + 8'h01;
    wire logic [7:0] dec_res = operand_a - 8'h01;

    // Result and flag effects of the current operation
    logic [7:0] next_result;
    logic       next_skip;
    logic       upd_c, upd_h, upd_z, upd_v;
    logic       new_c, new_h, new_v;

    always_comb begin
        next_result = operand_a;
        next_skip   = 1'b0;
        upd_c = 1'b0;
        upd_h = 1'b0;
        upd_z = 1'b0;
        upd_v = 1'b0;
        new_c = c_in;
        new_h = h_in;
        new_v = flag_q[alu_pkg::OVF_BIT];
        unique case (op)
            alu_pkg::OP_ADD, alu_pkg::OP_ADC, alu_pkg::OP_SUB,
            alu_pkg::SUBTRACT_WITH_BORROW_OP: begin
                next_result = add_res;
                upd_c = 1'b1;
                new_c = top_sum[1];
                upd_h = 1'b1;
                new_h = low_sum[4];
                upd_v = 1'b1;
                new_v = add_ovf;
                upd_z = 1'b1;
            end
            alu_pkg::DECIMAL_ADJUST_OP: begin
                next_result = da_s2[7:0];
                upd_c = 1'b1;
                new_c = da_c;
            end
            alu_pkg::OP_AND: begin
                next_result = operand_a & operand_b;
                upd_z = 1'b1;
            end
            alu_pkg::OP_OR: begin
                next_result = operand_a | operand_b;
                upd_z = 1'b1;
            end
            alu_pkg::OP_XOR: begin
                next_result = operand_a ^ operand_b;
                upd_z = 1'b1;
            end
            alu_pkg::COMPLEMENT_OP: begin
                next_result = ~operand_a;
                upd_z = 1'b1;
            end
            alu_pkg::ROTATE_LEFT_OP:  next_result = {operand_a[6:0], operand_a[7]};
            alu_pkg::ROTATE_RIGHT_OP: next_result = {operand_a[0], operand_a[7:1]};
            alu_pkg::ROTATE_LEFT_THROUGH_CARRY_OP: begin
                next_result = {operand_a[6:0], c_in};
                upd_c = 1'b1;
                new_c = operand_a[7];
            end
            alu_pkg::ROTATE_RIGHT_THROUGH_CARRY_OP: begin
                next_result = {c_in, operand_a[7:1]};
                upd_c = 1'b1;
                new_c = operand_a[0];
            end
            alu_pkg::OP_INC: begin
                next_result = inc_res;
                upd_z = 1'b1;
            end
            alu_pkg::DECREMENT_OP: begin
                next_result = dec_res;
                upd_z = 1'b1;
            end
            alu_pkg::SKIP_IF_ZERO_OP:    next_skip = (operand_a == 8'h00);
            alu_pkg::SKIP_IF_NONZERO_OP: next_skip = (operand_a != 8'h00);
            alu_pkg::INCREMENT_SKIP_ZERO_OP: begin
                next_result = inc_res;
                next_skip   = (inc_res == 8'h00);
            end
            alu_pkg::DECREMENT_SKIP_ZERO_OP: begin
                next_result = dec_res;
                next_skip   = (dec_res == 8'h00);
            end
            alu_pkg::OP_NONE, alu_pkg::OP_PASS: next_result = operand_a;
            default: next_result = operand_a;
        endcase
    end

    // Register write and read decode
    wire logic flag_wr = reg_write && (reg_addr == alu_pkg::FLAG_REG_ADDR);
    wire logic flag_rd = reg_read && (reg_addr == alu_pkg::FLAG_REG_ADDR);
    wire logic alu_go  = op_valid && !flag_wr;

    logic [3:0] next_arith;
    always_comb begin
        next_arith = flag_q[3:0];
        if (flag_wr) begin
            next_arith = reg_wdata[3:0] & alu_pkg::FLAG_SW_MASK[3:0];
        end else if (alu_go) begin
            if (upd_c) next_arith[alu_pkg::CARRY_BIT] = new_c;
            if (upd_h) next_arith[alu_pkg::HALF_BIT]  = new_h;
            if (upd_z) next_arith[alu_pkg::ZERO_BIT]  = (next_result == 8'h00);
            if (upd_v) next_arith[alu_pkg::OVF_BIT]   = new_v;
        end
    end

    // timeout and power-down flag events, timeout set wins
    logic [1:0] next_event;
    always_comb begin
        next_event = event_q;
        if (halt_instruction) begin
            next_event = 2'b01;
        end else if (watchdog_clear_instruction) begin
            next_event = 2'b00;
        end
        if (watchdog_timeout) next_event[1] = 1'b1;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q  <= alu_pkg::FLAG_RESET;
            event_q <= 2'b00;
        end else begin
            flag_q  <= {4'h0, next_arith};
            event_q <= next_event;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            result       <= 8'h00;
            result_valid <= 1'b0;
            skip_next    <= 1'b0;
            reg_rdata    <= 8'h00;
        end else begin
            result       <= alu_go ? next_result : result;
            result_valid <= alu_go;
            skip_next    <= alu_go && next_skip;
            reg_rdata    <= flag_rd ? flags : 8'h00;
        end
    end

    assign flags = {2'b00, event_q, flag_q[3:0]} & alu_pkg::FLAG_READ_MASK;

    a_timeout_set: assert property (@(posedge clk) disable iff (rst)
        watchdog_timeout |=> flags[alu_pkg::TIMEOUT_BIT])
        else $error("timeout flag not set");
    a_halt_flags: assert property (@(posedge clk) disable iff (rst)
        halt_instruction && !watchdog_timeout |=> flags[5:4] == 2'b01)
        else $error("halt flags wrong");
    a_write_keeps: assert property (@(posedge clk) disable iff (rst)
        flag_wr && !halt_instruction && !watchdog_clear_instruction && !watchdog_timeout
        |=> $stable(flags[5:4]))
        else $error("write changed event flags");
    a_top_zero: assert property (@(posedge clk) disable iff (rst)
        flags[7:6] == 2'b00)
        else $error("top bits nonzero");
    a_zero_flag: assert property (@(posedge clk) disable iff (rst)
        alu_go && upd_z |=> flags[alu_pkg::ZERO_BIT] == (result == 8'h00))
        else $error("zero flag mismatch");
    a_add_carry: assert property (@(posedge clk) disable iff (rst)
        alu_go && op == alu_pkg::OP_ADD
        |=> flags[alu_pkg::CARRY_BIT] == ({1'b0, $past(operand_a)} + {1'b0, $past(operand_b)} > 9'h0ff))
        else $error("add carry wrong");
    a_rot_carry: assert property (@(posedge clk) disable iff (rst)
        alu_go && op == alu_pkg::ROTATE_LEFT_THROUGH_CARRY_OP
        |=> flags[0] == $past(operand_a[7]) && result[0] == $past(c_in))
        else $error("rotate carry wrong");
    a_skip_zero: assert property (@(posedge clk) disable iff (rst)
        alu_go && op == alu_pkg::INCREMENT_SKIP_ZERO_OP |=> skip_next == (result == 8'h00))
        else $error("skip decision wrong");
    a_sw_write: assert property (@(posedge clk) disable iff (rst)
        flag_wr |=> flags[3:0] == $past(reg_wdata[3:0]))
        else $error("flag write lost");

    // Read of the flag register returns the image of the cycle before
    sequence s_flag_read;
        reg_read && (reg_addr == alu_pkg::FLAG_REG_ADDR);
    endsequence

    a_read_image: assert property (@(posedge clk) disable iff (rst)
        s_flag_read |=> reg_rdata == $past(flags))
        else $error("flag read image wrong");
    a_sub_carry: assert property (@(posedge clk) disable iff (rst)
        alu_go && op == alu_pkg::OP_SUB
        |=> flags[alu_pkg::CARRY_BIT] == ($past(operand_a) >= $past(operand_b)))
        else $error("subtract carry wrong");
    a_half_add: assert property (@(posedge clk) disable iff (rst)
        alu_go && op == alu_pkg::OP_ADD
        |=> flags[alu_pkg::HALF_BIT] == ($past(operand_a[3:0]) + $past(operand_b[3:0]) > 5'h0f))
        else $error("half carry wrong");
    a_ovf_add: assert property (@(posedge clk) disable iff (rst)
        alu_go && op == alu_pkg::OP_ADD |=> flags[alu_pkg::OVF_BIT]
        == (($past(operand_a[7]) == $past(operand_b[7])) && (result[7] != $past(operand_a[7]))))
        else $error("overflow flag wrong");
    a_clear_flags: assert property (@(posedge clk) disable iff (rst)
        watchdog_clear_instruction && !halt_instruction && !watchdog_timeout
        |=> flags[5:4] == 2'b00)
        else $error("watchdog clear flags wrong");
    a_op_pulse: assert property (@(posedge clk) disable iff (rst)
        alu_go |=> result_valid)
        else $error("result valid missing");
    a_dec_skip: assert property (@(posedge clk) disable iff (rst)
        alu_go && op == alu_pkg::DECREMENT_SKIP_ZERO_OP |=> skip_next == (result == 8'h00))
        else $error("decrement skip wrong");

endmodule

// File: sim/alu_with_flag_register_tb.sv
`timescale 1ns/10ps
module alu_with_flag_register_tb;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       op_valid = 1'b0;
    logic [4:0] op_code = 5'h00;
    logic [7:0] operand_a = 8'h00;
    logic [7:0] operand_b = 8'h00;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic       reg_write = 1'b0;
    logic       reg_read = 1'b0;
    logic [7:0] result, reg_rdata, flags, saved;
    logic       result_valid, skip_next, wclr, hlt, wto;
    int         miscompares = 0;
    int         n_tests = 0;
    int         cycles = 0;

    always #12.5 clk = ~clk;

    alu_with_flag_register alu_with_flag_register_inst (
        .clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .operand_a(operand_a), .operand_b(operand_b), .result(result),
        .result_valid(result_valid), .skip_next(skip_next), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .watchdog_clear_instruction(wclr),
        .halt_instruction(hlt), .watchdog_timeout(wto), .flags(flags));

    core_event_model core_event_model_inst (
        .clk(clk), .watchdog_clear_instruction(wclr),
        .halt_instruction(hlt), .watchdog_timeout(wto));

    task automatic close_out;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Hang guard: the whole run needs about a hundred cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            miscompares++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // One operation; result masked by rm, whole flag image compared
    task automatic run(input alu_pkg::alu_op_e op, input logic [7:0] a, b, r, rm,
                       input logic s, input logic [7:0] f);
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= op;
        operand_a <= a;
        operand_b <= b;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("result_valid", 8'h01, {7'h00, result_valid});
        chk("result", r & rm, result & rm);
        chk("skip_next", {7'h00, s}, {7'h00, skip_next});
        chk("flags", f, flags);
    endtask

    task automatic regs_scn;
        chk("flags after reset", 8'h00, flags);
        wr(8'h0a, 8'hff);
        chk("flags written", 8'h0f, flags);
        rd(8'h0a, saved);
        chk("flag read", 8'h0f, saved);
        rd(8'h0b, saved);
        chk("unmapped read", 8'h00, saved);
        wr(8'h0b, 8'h00);
        chk("unmapped write", 8'h0f, flags);
        wr(8'h0a, 8'h00);
    endtask

    task automatic ops_scn;
        run(alu_pkg::OP_ADD, 8'hff, 8'h01, 8'h00, 8'hff, 1'b0, 8'h07);
        run(alu_pkg::OP_ADC, 8'h01, 8'h01, 8'h03, 8'hff, 1'b0, 8'h00);
        run(alu_pkg::OP_SUB, 8'h05, 8'h03, 8'h02, 8'hff, 1'b0, 8'h03);
        run(alu_pkg::SUBTRACT_WITH_BORROW_OP, 8'h05, 8'h05, 8'h00, 8'hff, 1'b0, 8'h07);
        run(alu_pkg::OP_ADD, 8'h01, 8'h01, 8'h02, 8'hff, 1'b0, 8'h00);
        run(alu_pkg::SUBTRACT_WITH_BORROW_OP, 8'h05, 8'h05, 8'hff, 8'hff, 1'b0, 8'h00);
        run(alu_pkg::OP_ADD, 8'h7f, 8'h01, 8'h80, 8'hff, 1'b0, 8'h0a);
        run(alu_pkg::DECIMAL_ADJUST_OP, 8'haa, 8'h00, 8'h10, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::OP_AND, 8'hf0, 8'h3c, 8'h30, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::OP_XOR, 8'h55, 8'h55, 8'h00, 8'hff, 1'b0, 8'h0f);
        run(alu_pkg::OP_OR, 8'h12, 8'h21, 8'h33, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::COMPLEMENT_OP, 8'h0f, 8'h00, 8'hf0, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::ROTATE_LEFT_OP, 8'h81, 8'h00, 8'h03, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::ROTATE_RIGHT_OP, 8'h81, 8'h00, 8'hc0, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::ROTATE_LEFT_THROUGH_CARRY_OP, 8'h80, 8'h00, 8'h01, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::ROTATE_LEFT_THROUGH_CARRY_OP, 8'h00, 8'h00, 8'h01, 8'hff, 1'b0, 8'h0a);
        run(alu_pkg::ROTATE_RIGHT_THROUGH_CARRY_OP, 8'h01, 8'h00, 8'h00, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::OP_INC, 8'hff, 8'h00, 8'h00, 8'hff, 1'b0, 8'h0f);
        run(alu_pkg::DECREMENT_OP, 8'h02, 8'h00, 8'h01, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::SKIP_IF_ZERO_OP, 8'h00, 8'h00, 8'h00, 8'h00, 1'b1, 8'h0b);
        run(alu_pkg::SKIP_IF_ZERO_OP, 8'h05, 8'h00, 8'h00, 8'h00, 1'b0, 8'h0b);
        run(alu_pkg::SKIP_IF_NONZERO_OP, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 8'h0b);
        run(alu_pkg::SKIP_IF_NONZERO_OP, 8'h05, 8'h00, 8'h00, 8'h00, 1'b1, 8'h0b);
        run(alu_pkg::INCREMENT_SKIP_ZERO_OP, 8'hff, 8'h00, 8'h00, 8'hff, 1'b1, 8'h0b);
        run(alu_pkg::DECREMENT_SKIP_ZERO_OP, 8'h02, 8'h00, 8'h01, 8'hff, 1'b0, 8'h0b);
        run(alu_pkg::DECREMENT_SKIP_ZERO_OP, 8'h01, 8'h00, 8'h00, 8'hff, 1'b1, 8'h0b);
    endtask

    // Back-to-back ops, then an op colliding with a flag write
    task automatic order_scn;
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= alu_pkg::OP_ADD;
        operand_a <= 8'hff;
        operand_b <= 8'h01;
        @(posedge clk);
        op_code <= alu_pkg::OP_ADC;
        operand_a <= 8'h00;
        operand_b <= 8'h00;
        @(posedge clk);
        op_valid <= 1'b0;
        #1;
        chk("chained carry", 8'h01, result);
        @(posedge clk);
        op_valid <= 1'b1;
        reg_write <= 1'b1;
        reg_addr <= 8'h0a;
        reg_wdata <= 8'h05;
        @(posedge clk);
        op_valid <= 1'b0;
        reg_write <= 1'b0;
        #1;
        chk("dropped op", 8'h00, {7'h00, result_valid});
        chk("write wins", 8'h05, flags);
    endtask

    task automatic event_scn;
        rd(8'h0a, saved);
        run(alu_pkg::OP_ADD, 8'hff, 8'h01, 8'h00, 8'hff, 1'b0, 8'h07);
        wr(8'h0a, saved);
        chk("flags restored", 8'h05, flags);
        core_event_model_inst.pulse(0);
        chk("halt", 8'h15, flags);
        wr(8'h0a, 8'h00);
        chk("write keeps events", 8'h10, flags);
        core_event_model_inst.pulse(2);
        chk("timeout", 8'h30, flags);
        wr(8'h0a, 8'hcf);
        rd(8'h0a, saved);
        chk("read image", 8'h3f, saved);
        core_event_model_inst.pulse(0);
        chk("halt clears timeout", 8'h1f, flags);
        core_event_model_inst.pulse(1);
        chk("watchdog clear", 8'h0f, flags);
        core_event_model_inst.pulse(2);
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("power-up", 8'h00, flags);
    endtask

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        regs_scn();
        ops_scn();
        order_scn();
        event_scn();
        close_out();
    end
endmodule

// File: sim/core_event_model.sv
`timescale 1ns/10ps
module core_event_model (
    // Clock
    input  wire logic clk,
    // Event pulses toward the flag register
    output logic      watchdog_clear_instruction,
    output logic      halt_instruction,
    output logic      watchdog_timeout
);
    initial begin
        watchdog_clear_instruction = 1'b0;
        halt_instruction           = 1'b0;
        watchdog_timeout           = 1'b0;
    end

    // One-cycle pulse: 0 halt, 1 watchdog clear, 2 watchdog overflow
    task automatic pulse(input int k);
        @(posedge clk);
        halt_instruction <= (k == 0);
        watchdog_clear_instruction <= (k == 1);
        watchdog_timeout <= (k == 2);
        @(posedge clk);
        halt_instruction <= 1'b0;
        watchdog_clear_instruction <= 1'b0;
        watchdog_timeout <= 1'b0;
        // Let the flag update of this edge settle before the caller looks
        #1;
    endtask
endmodule
